/* File: logic/cfd_pkg.sv */
// constants for the configuration byte decoder
`default_nettype none
package cfd_pkg;
  localparam int CFD_NUM_BYTES = 5;
  localparam int CFD_I_PROT = 0;
  localparam int CFD_I_EXT = 1;
  localparam int CFD_I_SER = 2;
  localparam int CFD_I_DTM = 3;
  localparam int CFD_I_DEN = 4;
  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [23:0] CFD_IDX_PROT = 24'h300007;
  localparam logic [23:0] CFD_IDX_EXT = 24'h300008;
  localparam logic [23:0] CFD_IDX_SER = 24'h300009;
  localparam logic [23:0] CFD_IDX_DTM = 24'h30000A;
  localparam logic [23:0] CFD_IDX_DEN = 24'h30000B;
  localparam logic [23:0] CFD_IDX_CTRL = 24'h300010;
  localparam logic [23:0] CFD_IDX_STAT = 24'h300011;
  localparam logic [23:0] CFD_IDX_LOCK = 24'h300012;
  localparam logic [23:0] CFD_ADDR_PROT = {CFD_IDX_PROT[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_EXT = {CFD_IDX_EXT[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_SER = {CFD_IDX_SER[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_DTM = {CFD_IDX_DTM[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_DEN = {CFD_IDX_DEN[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_CTRL = {CFD_IDX_CTRL[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_STAT = {CFD_IDX_STAT[21:0], 2'b00};
  localparam logic [23:0] CFD_ADDR_LOCK = {CFD_IDX_LOCK[21:0], 2'b00};
  ////////////////////////////////////////////////////////////////////////////
  // reset value and readback masks
  localparam logic [7:0] CFD_CFG_RESET = 8'hFF;
  localparam logic [7:0] CFD_MASK_PROT = 8'h07;
  localparam logic [7:0] CFD_MASK_EXT = 8'hFB;
  localparam logic [7:0] CFD_MASK_SER = 8'h0F;
  localparam logic [7:0] CFD_MASK_DTM = 8'hFF;
  localparam logic [7:0] CFD_MASK_DEN = 8'h0F;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CFD_B_GUARD = 2;
  localparam int CFD_B_RDIR = 1;
  localparam int CFD_B_BYPASS = 0;
  localparam int CFD_B_NOWAIT = 7;
  localparam int CFD_B_BUSW = 6;
  localparam int CFD_B_ABW = 4;
  localparam int CFD_B_SHIFT = 3;
  localparam int CFD_B_CREMAP = 1;
  localparam int CFD_B_T5GS = 0;
  localparam int CFD_B_MSK1 = 3;
  localparam int CFD_B_MSK2 = 2;
  localparam int CFD_B_LS48 = 1;
  localparam int CFD_B_ONESHOT = 0;
  localparam int CFD_B_DPS = 4;
  localparam int CFD_B_DCLK = 2;
  localparam int CFD_B_DWIN = 0;
  localparam int CFD_B_PRESC = 3;
  localparam int CFD_B_WINOFF = 2;
  localparam int CFD_B_DEN = 0;
  localparam int CFD_B_SOFTDOG = 0;
  localparam int CFD_B_LOCK = 0;
  ////////////////////////////////////////////////////////////////////////////
  // field codes and values
  localparam logic [1:0] CFD_ABW_20 = 2'b00;
  localparam logic [1:0] CFD_ABW_16 = 2'b01;
  localparam logic [1:0] CFD_ABW_12 = 2'b10;
  localparam logic [1:0] CFD_ABW_OFF = 2'b11;
  localparam logic [1:0] CFD_DCLK_PER = 2'b00;
  localparam logic [1:0] CFD_DCLK_SECONDARY_OSCILLATOR = 2'b01;
  localparam logic [1:0] CFD_DCLK_LPRC = 2'b10;
  localparam logic [1:0] CFD_DCLK_FRC = 2'b11;
  localparam logic [1:0] CFD_DEN_OFF = 2'b00;
  localparam logic [1:0] CFD_DEN_AWAKE = 2'b01;
  localparam logic [1:0] CFD_DEN_SOFT = 2'b10;
  localparam logic [1:0] CFD_DEN_ON = 2'b11;
  localparam logic [3:0] CFD_WIN_25 = 4'h2;
  localparam logic [3:0] CFD_WIN_37 = 4'h3;
  localparam logic [3:0] CFD_WIN_50 = 4'h4;
  localparam logic [3:0] CFD_WIN_75 = 4'h6;
  localparam logic [7:0] CFD_PRESC_HI = 8'h80;
  localparam logic [7:0] CFD_PRESC_LO = 8'h20;
  localparam logic [3:0] CFD_LS_DIV_48 = 4'h8;
  localparam logic [3:0] CFD_LS_DIV_24 = 4'h4;
  localparam logic [7:0] CFD_LAST_PAGE = 8'hFF;
  localparam logic [7:0] CFD_UNLOCK_KEY = 8'h5A;
  typedef enum logic [3:0] {
    CFD_CK_PER = 4'h1, CFD_CK_SECONDARY_OSCILLATOR = 4'h2, CFD_CK_LPRC = 4'h4, CFD_CK_FRC = 4'h8
  } cfd_dogclk_e;
  typedef enum logic [1:0] {CFD_UL_IDLE = 2'b01, CFD_UL_ARMED = 2'b10} cfd_unlock_e;
endpackage
`default_nettype wire

/* File: logic/cfd_loader.sv */
// write-once configuration byte store, loaded from non-volatile words
`default_nettype none
module cfd_loader (
  // clock and reset
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic devReset,
  // non-volatile source and stored bytes
  input wire logic [7:0] nvByte [cfd_pkg::CFD_NUM_BYTES],
  output var logic [7:0] cfgByte [cfd_pkg::CFD_NUM_BYTES],
  output logic cfgLoading
);
  import cfd_pkg::*;
  logic loadPend_q;
  logic [7:0] cfgMem_q [CFD_NUM_BYTES];

  // power-on forces ones; any device reset reloads without that step
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      loadPend_q <= 1'b1;
    end else begin
      loadPend_q <= devReset;
    end
  end

  for (genvar i = 0; i < CFD_NUM_BYTES; i++) begin : g_byte
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        cfgMem_q[i] <= CFD_CFG_RESET;
      end else if (loadPend_q) begin
        cfgMem_q[i] <= nvByte[i];
      end
    end
    assign cfgByte[i] = cfgMem_q[i];
  end

  assign cfgLoading = loadPend_q;
endmodule
`default_nettype wire

/* File: logic/cfd_top.sv */
// configuration byte decoder with apb readback
//
// The APB interface to the registers is this design's own decision.
`default_nettype none
module cfd_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic devReset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // non-volatile configuration bytes
  input wire logic [7:0] nvProtByte,
  input wire logic [7:0] nvExtBusByte,
  input wire logic [7:0] nvSerialByte,
  input wire logic [7:0] nvDogTimeByte,
  input wire logic [7:0] nvDogEnByte,
  // flash protection
  input wire logic [7:0] protectPageIndex,
  input wire logic [7:0] flashOpPage,
  output logic flashOpBlocked,
  // external bus
  input wire logic [1:0] memCtlWait,
  input wire logic [20:0] pcValue,
  input wire logic [20:0] extRegionBase,
  output logic extNoWait,
  output logic [1:0] extWaitCount,
  output logic extBus16,
  output logic extBusEnable,
  output logic [1:0] extAddrWidth,
  output logic [19:0] extAddr,
  // pin routing and peripherals
  input wire logic portABitFive,
  input wire logic comp1DefaultPin,
  input wire logic comp3DefaultPin,
  input wire logic timer5GatePin,
  input wire logic timer3GatePin,
  output logic comparator1InputA,
  output logic comparator3InputA,
  output logic timer5Gate,
  output logic port1MaskWidth7,
  output logic port2MaskWidth7,
  output logic lowspeedClkEn,
  output logic pinMapLock,
  // watchdog
  input wire logic sysClkIsLprc,
  input wire logic deviceAsleep,
  output logic [15:0] dogPostscaleDiv,
  output logic [7:0] dogPrescaleDiv,
  output logic [3:0] dogClkSel,
  output logic [3:0] dogWindowEighths,
  output logic dogWindowed,
  output logic dogRun
);
  import cfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and byte store
  logic rstMeta_q;
  logic rstSyncN;
  logic cfgLoading;
  logic [7:0] nvByte [CFD_NUM_BYTES];
  logic [7:0] cfgByte [CFD_NUM_BYTES];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN <= rstMeta_q;
    end
  end

  assign nvByte[CFD_I_PROT] = nvProtByte;
  assign nvByte[CFD_I_EXT] = nvExtBusByte;
  assign nvByte[CFD_I_SER] = nvSerialByte;
  assign nvByte[CFD_I_DTM] = nvDogTimeByte;
  assign nvByte[CFD_I_DEN] = nvDogEnByte;

  cfd_loader u_loader (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .devReset(devReset),
    .nvByte(nvByte),
    .cfgByte(cfgByte),
    .cfgLoading(cfgLoading)
  );

  wire [7:0] prot = cfgByte[CFD_I_PROT];
  wire [7:0] ext = cfgByte[CFD_I_EXT];
  wire [7:0] ser = cfgByte[CFD_I_SER];
  wire [7:0] dtm = cfgByte[CFD_I_DTM];
  wire [7:0] den = cfgByte[CFD_I_DEN];

  ////////////////////////////////////////////////////////////////////////////
  // flash write protection
  wire bypass = prot[CFD_B_BYPASS];
  wire guardOff = prot[CFD_B_GUARD];
  wire rangeDir = prot[CFD_B_RDIR];
  wire upRange = flashOpPage >= protectPageIndex;
  wire downRange = flashOpPage <= protectPageIndex;
  wire inRange = rangeDir ? upRange : downRange;
  wire lastHit = !guardOff && (flashOpPage == CFD_LAST_PAGE);
  wire blockD = !bypass && (inRange || lastHit);

  ////////////////////////////////////////////////////////////////////////////
  // external bus
  wire noWait = ext[CFD_B_NOWAIT];
  wire [1:0] address_width_select = ext[CFD_B_ABW +: 2];
  wire [20:0] pcOffset = pcValue - extRegionBase;
  wire [19:0] rawAddr = ext[CFD_B_SHIFT] ? pcOffset[19:0] : pcValue[19:0];
  wire [19:0] addrMask = (address_width_select == CFD_ABW_20) ? 20'hFFFFF :
                         (address_width_select == CFD_ABW_16) ? 20'h0FFFF :
                         (address_width_select == CFD_ABW_12) ? 20'h00FFF : 20'h00000;
  wire [1:0] waitD = noWait ? 2'h0 : memCtlWait;

  ////////////////////////////////////////////////////////////////////////////
  // routing and serial port settings
  wire cmpRemap = ext[CFD_B_CREMAP];
  wire cmp1D = cmpRemap ? comp1DefaultPin : portABitFive;
  wire cmp3D = cmpRemap ? comp3DefaultPin : portABitFive;
  wire t5gD = ext[CFD_B_T5GS] ? timer5GatePin : timer3GatePin;
  wire ls48 = ser[CFD_B_LS48];
  wire oneShot = ser[CFD_B_ONESHOT];

  ////////////////////////////////////////////////////////////////////////////
  // watchdog settings
  wire [3:0] dps = dtm[CFD_B_DPS +: 4];
  wire [1:0] dclk = dtm[CFD_B_DCLK +: 2];
  wire [1:0] dwin = dtm[CFD_B_DWIN +: 2];
  wire winOff = den[CFD_B_WINOFF];
  wire [1:0] denMode = den[CFD_B_DEN +: 2];
  wire awakeFast = !sysClkIsLprc && !deviceAsleep;
  logic softDog_q;
  cfd_dogclk_e clkSelD;
  assign clkSelD = (dclk == CFD_DCLK_SECONDARY_OSCILLATOR) ? CFD_CK_SECONDARY_OSCILLATOR :
                   (dclk == CFD_DCLK_LPRC) ? CFD_CK_LPRC :
                   (dclk == CFD_DCLK_PER) ? (awakeFast ? CFD_CK_PER : CFD_CK_LPRC) :
                   ((awakeFast && !winOff) ? CFD_CK_FRC : CFD_CK_LPRC);
  wire [3:0] winD = (dwin == 2'b11) ? CFD_WIN_25 :
                    (dwin == 2'b10) ? CFD_WIN_37 :
                    (dwin == 2'b01) ? CFD_WIN_50 : CFD_WIN_75;
  wire runD = (denMode == CFD_DEN_ON) ? 1'b1 :
              (denMode == CFD_DEN_SOFT) ? softDog_q :
              (denMode == CFD_DEN_AWAKE) ? !deviceAsleep : 1'b0;
  wire [15:0] postD = 16'(16'h0001 << dps);
  wire [7:0] prescD = den[CFD_B_PRESC] ? CFD_PRESC_HI : CFD_PRESC_LO;

  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs, all registered
  // config bytes only change at a load, but outputs fed by live inputs such as flashOpPage, pcValue and deviceAsleep follow them each cycle
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      flashOpBlocked <= 1'b0;
      extNoWait <= 1'b0;
      extWaitCount <= 2'h0;
      extBus16 <= 1'b0;
      extBusEnable <= 1'b0;
      extAddrWidth <= CFD_ABW_OFF;
      extAddr <= 20'h00000;
      comparator1InputA <= 1'b0;
      comparator3InputA <= 1'b0;
      timer5Gate <= 1'b0;
      port1MaskWidth7 <= 1'b0;
      port2MaskWidth7 <= 1'b0;
      dogPostscaleDiv <= 16'h0000;
      dogPrescaleDiv <= 8'h00;
      dogClkSel <= CFD_CK_LPRC;
      dogWindowEighths <= 4'h0;
      dogWindowed <= 1'b0;
      dogRun <= 1'b0;
    end else begin
      flashOpBlocked <= blockD;
      extNoWait <= noWait;
      extWaitCount <= waitD;
      extBus16 <= ext[CFD_B_BUSW];
      extBusEnable <= address_width_select != CFD_ABW_OFF;
      extAddrWidth <= address_width_select;
      extAddr <= rawAddr & addrMask;
      comparator1InputA <= cmp1D;
      comparator3InputA <= cmp3D;
      timer5Gate <= t5gD;
      port1MaskWidth7 <= ser[CFD_B_MSK1];
      port2MaskWidth7 <= ser[CFD_B_MSK2];
      dogPostscaleDiv <= postD;
      dogPrescaleDiv <= prescD;
      dogClkSel <= clkSelD;
      dogWindowEighths <= winD;
      dogWindowed <= !winOff;
      dogRun <= runD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-speed usb clock enable from the system clock
  logic [3:0] lsCnt_q;
  wire [3:0] lsDiv = ls48 ? CFD_LS_DIV_48 : CFD_LS_DIV_24;
  wire lsWrap = lsCnt_q >= lsDiv - 4'h1;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lsCnt_q <= 4'h0;
      lowspeedClkEn <= 1'b0;
    end else begin
      lsCnt_q <= lsWrap ? 4'h0 : lsCnt_q + 4'h1;
      lowspeedClkEn <= lsWrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire hitProt = paddr == CFD_ADDR_PROT;
  wire hitExt = paddr == CFD_ADDR_EXT;
  wire hitSer = paddr == CFD_ADDR_SER;
  wire hitDtm = paddr == CFD_ADDR_DTM;
  wire hitDen = paddr == CFD_ADDR_DEN;
  wire hitCtrl = paddr == CFD_ADDR_CTRL;
  wire hitStat = paddr == CFD_ADDR_STAT;
  wire hitLock = paddr == CFD_ADDR_LOCK;
  wire hitCfg = hitProt || hitExt || hitSer || hitDtm || hitDen;
  wire mapped = hitCfg || hitCtrl || hitStat || hitLock;
  // write-once bytes refuse software writes, as does the status word
  wire badAcc = !mapped || (pwrite && (hitCfg || hitStat));
  wire [31:0] statWord = {22'h000000, cfgLoading, dogRun, dogClkSel,
                          dogWindowed, pinMapLock, extBusEnable, flashOpBlocked};
  wire [7:0] cfgRead = hitProt ? (prot & CFD_MASK_PROT) :
                       hitExt ? (ext & CFD_MASK_EXT) :
                       hitSer ? (ser & CFD_MASK_SER) :
                       hitDtm ? (dtm & CFD_MASK_DTM) :
                       hitDen ? (den & CFD_MASK_DEN) : 8'h00;
  wire [31:0] rdData = hitCfg ? {24'h000000, cfgRead} :
                       hitCtrl ? {31'h00000000, softDog_q} :
                       hitLock ? {31'h00000000, pinMapLock} :
                       hitStat ? statWord : 32'h00000000;
  wire accPhase = psel && penable;
  wire wrTake = accPhase && pready && pwrite && !badAcc;

  // one wait state keeps pready, prdata and pslverr straight from flops
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= accPhase && !pready;
      prdata <= (accPhase && !pready && !pwrite) ? rdData : 32'h00000000;
      pslverr <= accPhase && !pready && badAcc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software controls and pin-map lock
  cfd_unlock_e ulState_q;
  cfd_unlock_e ulState_d;
  wire lockWr = wrTake && hitLock;
  wire lockFrozen = oneShot && pinMapLock;
  wire lockApply = lockWr && (ulState_q == CFD_UL_ARMED) && !lockFrozen;

  always_comb begin
    ulState_d = ulState_q;
    case (ulState_q)
      CFD_UL_IDLE: begin
        if (lockWr && pwdata[7:0] == CFD_UNLOCK_KEY) begin
          ulState_d = CFD_UL_ARMED;
        end
      end
      CFD_UL_ARMED: begin
        if (lockWr) begin
          ulState_d = CFD_UL_IDLE;
        end
      end
      default: begin
        ulState_d = CFD_UL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ulState_q <= CFD_UL_IDLE;
      pinMapLock <= 1'b0;
      softDog_q <= 1'b0;
    end else begin
      ulState_q <= ulState_d;
      if (lockApply) begin
        pinMapLock <= pwdata[CFD_B_LOCK];
      end
      if (wrTake && hitCtrl) begin
        softDog_q <= pwdata[CFD_B_SOFTDOG];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  property p_last_page;
    (!bypass && !guardOff && flashOpPage == CFD_LAST_PAGE) |=> flashOpBlocked;
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page not blocked");

  property p_low_range;
    (!bypass && !rangeDir && flashOpPage <= protectPageIndex) |=> flashOpBlocked;
  endproperty
  a_low_range: assert property (p_low_range) else $error("low range not blocked");

  property p_high_range;
    (!bypass && rangeDir && flashOpPage >= protectPageIndex) |=> flashOpBlocked;
  endproperty
  a_high_range: assert property (p_high_range) else $error("high range not blocked");

  property p_bypass;
    bypass |=> !flashOpBlocked;
  endproperty
  a_bypass: assert property (p_bypass) else $error("blocked while bypassed");

  property p_no_wait;
    noWait |=> extNoWait && extWaitCount == 2'h0;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait with no-wait set");

  property p_bus_off;
    (address_width_select == CFD_ABW_OFF) |=> !extBusEnable && extAddr == 20'h00000;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus active when off");

  property p_cmp_remap;
    !cmpRemap |=> comparator1InputA == $past(portABitFive)
      && comparator3InputA == $past(portABitFive);
  endproperty
  a_cmp_remap: assert property (p_cmp_remap) else $error("comparator not remapped");

  property p_ls_eight;
    disable iff (!rstSyncN || cfgLoading)
    (lowspeedClkEn && ls48 && !cfgLoading) |=> !lowspeedClkEn [*7] ##1 lowspeedClkEn;
  endproperty
  a_ls_eight: assert property (p_ls_eight) else $error("low-speed not divide by 8");

  property p_lock_hold;
    (pinMapLock && oneShot) |=> pinMapLock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("one-shot lock cleared");

  property p_dog_mode;
    (denMode == CFD_DEN_ON) ##1 (denMode == CFD_DEN_ON) |-> dogRun;
  endproperty
  a_dog_mode: assert property (p_dog_mode) else $error("watchdog not forced on");

  property p_dog_off;
    (denMode == CFD_DEN_OFF) |=> !dogRun;
  endproperty
  a_dog_off: assert property (p_dog_off) else $error("watchdog runs when off");

  c_blocked: cover property (!bypass ##1 flashOpBlocked);
  c_lock_set: cover property (lockApply ##1 pinMapLock);
  c_apb_read: cover property (accPhase && !pwrite ##1 pready && !pslverr);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the configuration byte decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfd_pkg::*;
  typedef struct {
    logic [7:0] prot, ext, ser, dtm, den, page, op;
    logic lprc, sleep, blk, run;
    logic [3:0] ck, win;
    logic [19:0] addr;
  } cfdtb_row_s;
  logic clk = 1'b0, arst_n = 1'b0, devReset = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic pready, pslverr, rdErr;
  logic [7:0] nv [5] = '{default: 8'hFF};
  logic [7:0] protectPageIndex = 8'h0, flashOpPage = 8'h0;
  logic [1:0] memCtlWait = 2'b00, extWaitCount, extAddrWidth;
  logic [20:0] pcValue = 21'h0ABCDE, extRegionBase = 21'h008000;
  logic portABitFive = 1'b0, comp1DefaultPin = 1'b0, comp3DefaultPin = 1'b0;
  logic timer5GatePin = 1'b0, timer3GatePin = 1'b0, sysClkIsLprc = 1'b0, deviceAsleep = 1'b0;
  logic flashOpBlocked, extNoWait, extBus16, extBusEnable, comparator1InputA;
  logic comparator3InputA, timer5Gate, port1MaskWidth7, port2MaskWidth7, lowspeedClkEn;
  logic pinMapLock, dogWindowed, dogRun;
  logic [19:0] extAddr;
  logic [15:0] dogPostscaleDiv;
  logic [7:0] dogPrescaleDiv;
  logic [3:0] dogClkSel, dogWindowEighths;
  int mismatches = 0, checks_done = 0, lsc;
  cfdtb_row_s r;
  logic [7:0] masks [5] = '{CFD_MASK_PROT, CFD_MASK_EXT, CFD_MASK_SER, CFD_MASK_DTM, CFD_MASK_DEN};
  // page edges: index itself, one past it, last page with guard, bypass over guard
  cfdtb_row_s rows [7] = '{
    '{8'hFE, 8'hCB, 8'hF9, 8'hF3, 8'hF3, 8'h40, 8'h40, 0, 0, 1, 1, 4'h1, 4'h2, 20'hA3CDE},
    '{8'hFC, 8'h10, 8'hF6, 8'h16, 8'hFE, 8'h40, 8'h41, 0, 0, 0, 0, 4'h2, 4'h3, 20'h0BCDE},
    '{8'hF8, 8'h20, 8'hF5, 8'h29, 8'hF1, 8'h10, 8'hFF, 0, 1, 1, 0, 4'h4, 4'h4, 20'h00CDE},
    '{8'hFB, 8'h30, 8'hF9, 8'h3C, 8'hF3, 8'h00, 8'hFF, 0, 0, 0, 1, 4'h8, 4'h6, 20'h00000},
    '{8'hFC, 8'h40, 8'hF6, 8'h4C, 8'hF7, 8'h40, 8'h40, 0, 0, 1, 1, 4'h4, 4'h6, 20'hABCDE},
    '{8'hFE, 8'h80, 8'hF5, 8'h50, 8'hF0, 8'h40, 8'h3F, 1, 0, 0, 0, 4'h4, 4'h6, 20'hABCDE},
    '{8'hFA, 8'h08, 8'hF9, 8'h60, 8'hF1, 8'h80, 8'h7F, 0, 0, 0, 1, 4'h1, 4'h6, 20'hA3CDE}};
  always #4 clk = ~clk;
  cfd_top u_cfd_top (.clk, .arst_n, .devReset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .nvProtByte(nv[0]), .nvExtBusByte(nv[1]),
    .nvSerialByte(nv[2]), .nvDogTimeByte(nv[3]), .nvDogEnByte(nv[4]), .protectPageIndex,
    .flashOpPage, .flashOpBlocked, .memCtlWait, .pcValue, .extRegionBase, .extNoWait,
    .extWaitCount, .extBus16, .extBusEnable, .extAddrWidth, .extAddr, .portABitFive,
    .comp1DefaultPin, .comp3DefaultPin, .timer5GatePin, .timer3GatePin, .comparator1InputA,
    .comparator3InputA, .timer5Gate, .port1MaskWidth7, .port2MaskWidth7, .lowspeedClkEn,
    .pinMapLock, .sysClkIsLprc, .deviceAsleep, .dogPostscaleDiv, .dogPrescaleDiv, .dogClkSel,
    .dogWindowEighths, .dogWindowed, .dogRun);
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait: a slave that never answers ends the run
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic reload();
    @(posedge clk);
    devReset <= 1'b1;
    @(posedge clk);
    devReset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic por();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic lockw(input logic [7:0] v);
    apb(1'b1, CFD_ADDR_LOCK, 32'h5A);
    apb(1'b1, CFD_ADDR_LOCK, {24'h0, v});
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    por();
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      {nv[0], nv[1], nv[2], nv[3], nv[4]} <= {r.prot, r.ext, r.ser, r.dtm, r.den};
      protectPageIndex <= r.page;
      flashOpPage <= r.op;
      sysClkIsLprc <= r.lprc;
      deviceAsleep <= r.sleep;
      memCtlWait <= 2'(i);
      timer5GatePin <= i[0];
      timer3GatePin <= !i[0];
      portABitFive <= i[1];
      comp1DefaultPin <= !i[1];
      comp3DefaultPin <= i[2];
      reload();
      chk("blocked", flashOpBlocked, r.blk);
      chk("wait", {extNoWait, extWaitCount}, {r.ext[7], r.ext[7] ? 2'b00 : 2'(i)});
      chk("bus16", extBus16, r.ext[6]);
      chk("abw", {extBusEnable, extAddrWidth}, {r.ext[5:4] != 2'b11, r.ext[5:4]});
      chk("addr", extAddr, r.addr);
      chk("comp", {comparator1InputA, comparator3InputA},
        r.ext[1] ? {!i[1], i[2]} : {2{i[1]}});
      chk("t5gate", timer5Gate, r.ext[0] ? i[0] : !i[0]);
      chk("mask", {port1MaskWidth7, port2MaskWidth7}, r.ser[3:2]);
      chk("post", dogPostscaleDiv, 16'h0001 << r.dtm[7:4]);
      chk("clksel", dogClkSel, r.ck);
      chk("win", dogWindowEighths, r.win);
      chk("presc", dogPrescaleDiv, r.den[3] ? 8'h80 : 8'h20);
      chk("windowed", dogWindowed, !r.den[2]);
      chk("run", dogRun, r.run);
      lsc = 0;
      repeat (32) begin
        @(posedge clk);
        if (lowspeedClkEn === 1'b1) lsc++;
      end
      chk("ls pulses", lsc, r.ser[1] ? 4 : 8);
      for (int k = 0; k < 5; k++) begin
        apb(1'b0, CFD_ADDR_PROT + 24'(4 * k), 32'h0);
        chk("cfg byte", rdData, {24'h0, nv[k] & masks[k]});
        chk("cfg err", rdErr, 1'b0);
      end
    end
    apb(1'b1, CFD_ADDR_PROT, 32'h0);
    chk("wr err", rdErr, 1'b1);
    apb(1'b0, CFD_ADDR_PROT, 32'h0);
    chk("kept", rdData, {24'h0, nv[0] & 8'h07});
    apb(1'b0, 24'h000100, 32'h0);
    chk("unmapped err", rdErr, 1'b1);
    chk("unmapped data", rdData, 32'h0);
    lockw(8'h01);
    chk("lock set", pinMapLock, 1'b1);
    lockw(8'h00);
    chk("lock frozen", pinMapLock, 1'b1);
    nv[2] <= 8'hF8;
    nv[4] <= 8'hFE;
    reload();
    lockw(8'h01);
    chk("lock set", pinMapLock, 1'b1);
    lockw(8'h00);
    chk("lock clear", pinMapLock, 1'b0);
    apb(1'b1, CFD_ADDR_LOCK, 32'h1);
    repeat (2) @(posedge clk);
    chk("no key", pinMapLock, 1'b0);
    apb(1'b1, CFD_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk("soft run", dogRun, 1'b1);
    apb(1'b0, CFD_ADDR_CTRL, 32'h0);
    chk("ctrl read", rdData, 32'h1);
    // status: run, peripheral clock, bus enabled, no window, unlocked, not blocked
    apb(1'b0, CFD_ADDR_STAT, 32'h0);
    chk("status", rdData, 32'h112);
    nv[2] <= 8'hF3;
    por();
    apb(1'b0, CFD_ADDR_SER, 32'h0);
    chk("por reload", rdData, 32'h03);
    final_report();
  end
endmodule
`default_nettype wire
